/* File: design/fbsc_comm_ctrl.sv */
// Fieldbus slave communication control: station address selection,
// communication state machine, traffic gating and process data timing.
// Assumes the link controller outside delivers requests as one-cycle strobes.
//
// Contract
// - Address source: 0 auto, 1 configured
// - Configured ID 0..32767, default 2, restart-activated
// - Free running applies data without sync
// - Distributed clock reads data on arrival
// - Distributed clock holds data until sync
// - Computation ready before sync, act on it
// - Upward steps strictly in order, skips refused
// - Downward skips accepted
// - Failed transition reports error to master
// - Init refuses mailbox and process data
// - Pre-Operational: mailbox only, no process data
// - Safe-Operational: mailbox, transmit only
// - Operational: mailbox, receive and transmit
// - Update per sync cycle, else aperiodic
`timescale 1ns/1ns
`default_nettype none

module fbsc_comm_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    restart,
  input  wire logic                    dc_mode,
  input  wire logic                    first_sync_pulse,
  input  wire logic [15:0]             auto_addr,
  input  wire fbsc_pkg::fbsc_al_req_s    al_req,
  input  wire fbsc_pkg::fbsc_param_req_s param_req,
  input  wire fbsc_pkg::fbsc_pdo_s       rx_pdo,
  input  wire logic                    tx_req,
  input  wire fbsc_pkg::fbsc_pdo_t       drive_status,
  output var  fbsc_pkg::fbsc_state_e     al_state,
  output var  logic                    al_err,
  output var  logic [15:0]             station_addr,
  output var  logic                    param_ack,
  output var  logic                    param_err,
  output var  logic [15:0]             param_rdata,
  output var  fbsc_pkg::fbsc_pdo_s       tx_pdo,
  output var  fbsc_pkg::fbsc_pdo_s       drive_cmd
);

  typedef struct packed {
    fbsc_pkg::fbsc_state_e state;
    logic [15:0]           id_value;
    logic [15:0]           id_source;
    logic                  loaded;
    logic                  act_auto;
    logic [15:0]           act_id;
    logic [15:0]           addr;
    logic                  al_err;
    logic                  ack;
    logic                  err;
    logic [15:0]           rdata;
    fbsc_pkg::fbsc_pdo_s   tx;
  } fbsc_ctrl_s;

  fbsc_ctrl_s cur_r;
  fbsc_ctrl_s cur_nxt;
  logic [1:0] cs;
  logic [1:0] tgt;
  logic [1:0] cs_inc;
  logic       rx_en;
  logic       tx_en;
  logic       mbx_en;

  assign cs     = cur_r.state;
  assign tgt    = al_req.target;
  assign cs_inc = cs + fbsc_pkg::STATE_STEP;
  assign mbx_en = cur_r.state != fbsc_pkg::ST_INIT;
  assign tx_en  = cur_r.state == fbsc_pkg::ST_SAFEOP || cur_r.state == fbsc_pkg::ST_OP;
  assign rx_en  = cur_r.state == fbsc_pkg::ST_OP;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_nxt        = cur_r;
    cur_nxt.al_err = 1'b0;
    cur_nxt.ack    = 1'b0;
    cur_nxt.err    = 1'b0;
    cur_nxt.tx.valid = 1'b0;

    // Stored settings only become active at load after reset or on restart
    if (!cur_r.loaded || restart) begin
      cur_nxt.loaded   = 1'b1;
      cur_nxt.act_auto = cur_r.id_source == fbsc_pkg::STATION_SRC_AUTO;
      cur_nxt.act_id   = cur_r.id_value;
    end
    cur_nxt.addr = cur_r.act_auto ? auto_addr : cur_r.act_id;

    if (al_req.valid) begin
      case (cur_r.state)
        fbsc_pkg::ST_INIT, fbsc_pkg::ST_PREOP, fbsc_pkg::ST_SAFEOP, fbsc_pkg::ST_OP: begin
          if (tgt <= cs) begin
            cur_nxt.state = al_req.target;
          end else if (tgt == cs_inc) begin
            cur_nxt.state = al_req.target;
          end else begin
            cur_nxt.al_err = 1'b1;
          end
        end
        default: begin
          cur_nxt.state = fbsc_pkg::ST_INIT;
        end
      endcase
    end

    // Parameter access rides on the mailbox
    if (param_req.valid) begin
      cur_nxt.ack   = 1'b1;
      cur_nxt.rdata = fbsc_pkg::RDATA_ZERO;
      if (!mbx_en) begin
        cur_nxt.err = 1'b1;
      end else if (param_req.index == fbsc_pkg::IDX_STATION_ID_VALUE) begin
        if (!param_req.write) begin
          cur_nxt.rdata = cur_r.id_value;
        end else if (param_req.wdata > fbsc_pkg::STATION_ID_MAX) begin
          cur_nxt.err = 1'b1;
        end else begin
          cur_nxt.id_value = param_req.wdata;
        end
      end else if (param_req.index == fbsc_pkg::IDX_STATION_ID_SOURCE) begin
        if (!param_req.write) begin
          cur_nxt.rdata = cur_r.id_source;
        end else if (param_req.wdata > fbsc_pkg::STATION_SRC_MAX) begin
          cur_nxt.err = 1'b1;
        end else begin
          cur_nxt.id_source = param_req.wdata;
        end
      end else begin
        cur_nxt.err = 1'b1;
      end
    end

    // Transmit once per sync cycle or on demand when free running
    if (tx_en && (dc_mode ? first_sync_pulse : tx_req)) begin
      cur_nxt.tx.valid = 1'b1;
      cur_nxt.tx.data  = drive_status;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_r           <= '0;
      cur_r.state     <= fbsc_pkg::ST_INIT;
      cur_r.id_value  <= fbsc_pkg::RST_STATION_ID_VALUE;
      cur_r.id_source <= fbsc_pkg::RST_STATION_ID_SOURCE;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Received data path
  // ----------------------------------------------------------------
  fbsc_pdo_hold u_hold (
    .clk        (clk),
    .rst        (rst),
    .rx_en      (rx_en),
    .dc_mode    (dc_mode),
    .rx         (rx_pdo),
    .sync_pulse (first_sync_pulse),
    .apply      (drive_cmd)
  );

  assign al_state     = cur_r.state;
  assign al_err       = cur_r.al_err;
  assign station_addr = cur_r.addr;
  assign param_ack    = cur_r.ack;
  assign param_err    = cur_r.err;
  assign param_rdata  = cur_r.rdata;
  assign tx_pdo       = cur_r.tx;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SKIP_REFUSED: assert property (@(posedge clk) disable iff (rst)
    al_req.valid && int'(al_req.target) > int'(al_state) + 1 |=> al_err && al_state == $past(al_state))
    else $error("Upward skip not refused");

  AST_STEP_UP: assert property (@(posedge clk) disable iff (rst)
    al_req.valid && int'(al_req.target) == int'(al_state) + 1 |=> !al_err && al_state == $past(al_req.target))
    else $error("Single upward step not taken");

  AST_DOWN_SKIP: assert property (@(posedge clk) disable iff (rst)
    al_req.valid && int'(al_req.target) <= int'(al_state) |=> !al_err && al_state == $past(al_req.target))
    else $error("Downward transition not taken");

  AST_ERR_CAUSE: assert property (@(posedge clk) disable iff (rst)
    al_err |-> $past(al_req.valid) && int'($past(al_req.target)) > int'($past(al_state)) + 1)
    else $error("Transition error without failed request");

  AST_INIT_MBX: assert property (@(posedge clk) disable iff (rst)
    param_req.valid && al_state == fbsc_pkg::ST_INIT |=> param_ack && param_err)
    else $error("Mailbox served in Init");

  AST_TX_GATE: assert property (@(posedge clk) disable iff (rst)
    tx_pdo.valid |-> $past(al_state) == fbsc_pkg::ST_SAFEOP || $past(al_state) == fbsc_pkg::ST_OP)
    else $error("Transmit data outside Safe-Operational or Operational");

  AST_RX_GATE: assert property (@(posedge clk) disable iff (rst)
    (al_state != fbsc_pkg::ST_OP) [*2] |=> !drive_cmd.valid)
    else $error("Received data applied outside Operational");

  AST_ID_RANGE: assert property (@(posedge clk) disable iff (rst)
    param_req.valid && param_req.write && param_req.index == fbsc_pkg::IDX_STATION_ID_VALUE
      && param_req.wdata > fbsc_pkg::STATION_ID_MAX && al_state != fbsc_pkg::ST_INIT |=> param_err)
    else $error("Out of range station ID accepted");

  AST_ID_RESTART: assert property (@(posedge clk) disable iff (rst)
    cur_r.loaded && !restart && !cur_r.act_auto ##1 !restart |=> $stable(station_addr))
    else $error("Station address changed without restart");

  AST_RESET_INIT: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> al_state == fbsc_pkg::ST_INIT)
    else $error("State not Init after reset");

endmodule : fbsc_comm_ctrl

`default_nettype wire

/* File: design/fbsc_pkg.sv */
// Constants, parameter indexes and carrier types of the fieldbus slave
// communication control. Assumes one clock domain at 100 MHz.
package fbsc_pkg;

  // ----------------------------------------------------------------
  // Parameter indexes and values
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_STATION_ID_VALUE  = 16'h2023;
  localparam logic [15:0] IDX_STATION_ID_SOURCE = 16'h2024;
  localparam logic [15:0] RST_STATION_ID_VALUE  = 16'h0002;
  localparam logic [15:0] RST_STATION_ID_SOURCE = 16'h0001;
  localparam logic [15:0] STATION_ID_MAX        = 16'h7FFF;
  localparam logic [15:0] STATION_SRC_MAX       = 16'h0001;
  localparam logic [15:0] STATION_SRC_AUTO      = 16'h0000;
  localparam logic [15:0] RDATA_ZERO            = 16'h0000;
  localparam logic [1:0]  STATE_STEP            = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  localparam int PDO_W = 32;

  typedef logic [PDO_W-1:0] fbsc_pdo_t;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_PREOP,
    ST_SAFEOP,
    ST_OP
  } fbsc_state_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [15:0] wdata;
  } fbsc_param_req_s;

  typedef struct packed {
    logic        valid;
    fbsc_state_e target;
  } fbsc_al_req_s;

  typedef struct packed {
    logic      valid;
    fbsc_pdo_t data;
  } fbsc_pdo_s;

endpackage : fbsc_pkg

/* File: design/fbsc_pdo_hold.sv */
// Received process data path: direct apply when free running, or hold and
// apply on the first sync pulse under distributed clocks.
// Assumes rx_en is high only in Operational.
`timescale 1ns/1ns
`default_nettype none

module fbsc_pdo_hold (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              rx_en,
  input  wire logic              dc_mode,
  input  wire fbsc_pkg::fbsc_pdo_s rx,
  input  wire logic              sync_pulse,
  output var  fbsc_pkg::fbsc_pdo_s apply
);

  typedef struct packed {
    fbsc_pkg::fbsc_pdo_t hold;
    logic                fresh;
    fbsc_pkg::fbsc_pdo_s out;
  } fbsc_hold_s;

  fbsc_hold_s cur_r;
  fbsc_hold_s cur_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_nxt           = cur_r;
    cur_nxt.out.valid = 1'b0;
    if (!rx_en) begin
      cur_nxt.fresh = 1'b0;
    end else if (dc_mode) begin
      // Sync consumes first so that a same-cycle arrival stays held
      if (sync_pulse && cur_r.fresh) begin
        cur_nxt.out.valid = 1'b1;
        cur_nxt.out.data  = cur_r.hold;
        cur_nxt.fresh     = 1'b0;
      end
      // Data later than the pulse waits for the next cycle's pulse
      if (rx.valid) begin
        cur_nxt.hold  = rx.data;
        cur_nxt.fresh = 1'b1;
      end
    end else if (rx.valid) begin
      cur_nxt.out = rx;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign apply = cur_r.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DC_APPLY_ON_SYNC: assert property (@(posedge clk) disable iff (rst)
    apply.valid && $past(dc_mode) |-> $past(sync_pulse) && $past(rx_en))
    else $error("Held data applied without a sync pulse");

  AST_FREE_APPLY: assert property (@(posedge clk) disable iff (rst)
    !dc_mode && rx_en && rx.valid |=> apply.valid && apply.data == $past(rx.data))
    else $error("Free running data not applied next cycle");

  AST_DC_READ_NOW: assert property (@(posedge clk) disable iff (rst)
    dc_mode && rx_en && rx.valid ##1 rx_en && dc_mode && sync_pulse |=> apply.valid && apply.data == $past(rx.data, 2))
    else $error("Arrived data not held for the following sync");

endmodule : fbsc_pdo_hold

`default_nettype wire

/* File: verification/fbsc_master_model.sv */
// Behavioural fieldbus master: state requests, parameter access,
// process data, sync and transmit strobes. Bench calls one task at a time.
`timescale 1ns/1ns
`default_nettype none

module fbsc_master_model (
  input  wire logic                      clk,
  output var  fbsc_pkg::fbsc_al_req_s    al_req,
  output var  fbsc_pkg::fbsc_param_req_s param_req,
  output var  fbsc_pkg::fbsc_pdo_s       rx_pdo,
  output var  logic                      first_sync_pulse,
  output var  logic                      tx_req
);
  // ------------------
  // Strobes
  // ------------------
  initial begin
    al_req = '0;
    param_req = '0;
    rx_pdo = '0;
    first_sync_pulse = 1'h0;
    tx_req = 1'h0;
  end

  task al(input fbsc_pkg::fbsc_state_e t);
    @(negedge clk) al_req <= '{1'h1, t};
    @(negedge clk) al_req.valid <= 1'h0;
  endtask : al

  // Released fields carry inverted data so stale values never match
  task prm(input logic w, input logic [15:0] i, input logic [15:0] d);
    @(negedge clk) param_req <= '{1'h1, w, i, d};
    @(negedge clk) param_req <= '{1'h0, w, ~i, ~d};
  endtask : prm

  task rx(input fbsc_pkg::fbsc_pdo_t d);
    @(negedge clk) rx_pdo <= '{1'h1, d};
    @(negedge clk) rx_pdo <= '{1'h0, ~d};
  endtask : rx

  task pls(input logic s);
    @(negedge clk) {first_sync_pulse, tx_req} <= {s, !s};
    @(negedge clk) {first_sync_pulse, tx_req} <= 2'h0;
  endtask : pls
endmodule : fbsc_master_model
`default_nettype wire

/* File: verification/tb_fbsc_comm_ctrl.sv */
// Self-checking bench of the slave communication control.
// Assumes the master model drives all strobes on falling edges.
`timescale 1ns/1ns
`default_nettype none

module tb_fbsc_comm_ctrl;
  logic                      clk, rst, restart, dc_mode, al_err, param_ack, param_err;
  logic [15:0]               auto_addr, station_addr, param_rdata, v;
  fbsc_pkg::fbsc_pdo_t       ds, d;
  fbsc_pkg::fbsc_al_req_s    al_req;
  fbsc_pkg::fbsc_param_req_s param_req;
  fbsc_pkg::fbsc_pdo_s       rx_pdo, tx_pdo, drive_cmd;
  fbsc_pkg::fbsc_state_e     al_state;
  logic                      sp, tx_req;
  int                        n_fail, comparisons, i;

  fbsc_master_model fbsc_master_model_inst (.clk(clk), .al_req(al_req), .param_req(param_req),
    .rx_pdo(rx_pdo), .first_sync_pulse(sp), .tx_req(tx_req));
  fbsc_comm_ctrl fbsc_comm_ctrl_inst (.clk(clk), .rst(rst), .restart(restart), .dc_mode(dc_mode),
    .first_sync_pulse(sp), .auto_addr(auto_addr), .al_req(al_req), .param_req(param_req),
    .rx_pdo(rx_pdo), .tx_req(tx_req), .drive_status(ds), .al_state(al_state), .al_err(al_err),
    .station_addr(station_addr), .param_ack(param_ack), .param_err(param_err),
    .param_rdata(param_rdata), .tx_pdo(tx_pdo), .drive_cmd(drive_cmd));

  // ------------------
  // Tasks
  // ------------------
  // Wide enough for a process data word with its valid bit on top
  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task go(input fbsc_pkg::fbsc_state_e t, input logic e, input fbsc_pkg::fbsc_state_e s);
    // Answer pulses stand one cycle: look on the falling edge the call returns on
    fbsc_master_model_inst.al(t);
    chk("al_err", e, al_err);
    chk("al_state", s, al_state);
  endtask : go

  task pa(input logic w, input logic [15:0] x, input logic [15:0] y, input logic e, input logic [15:0] r);
    fbsc_master_model_inst.prm(w, x, y);
    chk("param_ack", 1, param_ack);
    chk("param_err", e, param_err);
    if (!e && !w) chk("param_rdata", r, param_rdata);
  endtask : pa

  // Restart taken, settings loaded, address shown two edges later
  task rs;
    restart = 1'h1;
    @(negedge clk) restart = 1'h0;
    repeat (3) @(negedge clk);
  endtask : rs

  task pd(input logic s, input logic e, input logic [31:0] x, input string nm);
    fbsc_master_model_inst.pls(s);
    if (nm == "tx_pdo") chk(nm, {e, x}, {tx_pdo.valid, (e ? tx_pdo.data : x)});
    else chk(nm, {e, x}, {drive_cmd.valid, (e ? drive_cmd.data : x)});
  endtask : pd

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    results;
  end

  initial begin
    {rst, restart, dc_mode, auto_addr, ds} = {1'h1, 50'h0};
    ds = $urandom(37);
    repeat (2) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    chk("al_state", fbsc_pkg::ST_INIT, al_state);
    chk("station_addr", 2, station_addr);
    pa(1'h0, fbsc_pkg::IDX_STATION_ID_SOURCE, 0, 1'h1, 0);
    go(fbsc_pkg::ST_SAFEOP, 1'h1, fbsc_pkg::ST_INIT);
    go(fbsc_pkg::ST_OP, 1'h1, fbsc_pkg::ST_INIT);
    go(fbsc_pkg::ST_PREOP, 1'h0, fbsc_pkg::ST_PREOP);
    go(fbsc_pkg::ST_OP, 1'h1, fbsc_pkg::ST_PREOP);
    pa(1'h0, fbsc_pkg::IDX_STATION_ID_SOURCE, 0, 1'h0, 1);
    for (i = 0; i < 2; i++) begin
      v = i ? 16'($urandom & 32'h7FFF) : 16'h7FFF;
      pa(1'h1, fbsc_pkg::IDX_STATION_ID_VALUE, v, 1'h0, 0);
      pa(1'h0, fbsc_pkg::IDX_STATION_ID_VALUE, 0, 1'h0, v);
      chk("station_addr", i ? 16'h7FFF : 16'h0002, station_addr);
      rs;
      chk("station_addr", v, station_addr);
    end
    pa(1'h1, fbsc_pkg::IDX_STATION_ID_VALUE, 16'h8000, 1'h1, 0);
    pa(1'h1, fbsc_pkg::IDX_STATION_ID_SOURCE, 16'h0002, 1'h1, 0);
    pa(1'h1, 16'h2025, 0, 1'h1, 0);
    pa(1'h1, fbsc_pkg::IDX_STATION_ID_SOURCE, 0, 1'h0, 0);
    auto_addr = 16'($urandom);
    rs;
    chk("station_addr", auto_addr, station_addr);
    d = $urandom;
    fbsc_master_model_inst.rx(d);
    chk("drive_cmd.valid", 0, drive_cmd.valid);
    pd(1'h0, 1'h0, 0, "tx_pdo");
    go(fbsc_pkg::ST_SAFEOP, 1'h0, fbsc_pkg::ST_SAFEOP);
    pd(1'h0, 1'h1, ds, "tx_pdo");
    fbsc_master_model_inst.rx(d);
    chk("drive_cmd.valid", 0, drive_cmd.valid);
    go(fbsc_pkg::ST_OP, 1'h0, fbsc_pkg::ST_OP);
    for (i = 0; i < 3; i++) begin
      d = $urandom;
      fbsc_master_model_inst.rx(d);
      chk("drive_cmd", {1'h1, d}, {drive_cmd.valid, drive_cmd.data});
    end
    dc_mode = 1'h1;
    fbsc_master_model_inst.rx(~d);
    chk("drive_cmd.valid", 0, drive_cmd.valid);
    d = $urandom;
    fbsc_master_model_inst.rx(d);
    pd(1'h1, 1'h1, d, "drive_cmd");
    chk("tx_pdo", {1'h1, ds}, {tx_pdo.valid, tx_pdo.data});
    @(negedge clk);
    chk("drive_cmd.valid", 0, drive_cmd.valid);
    pd(1'h1, 1'h0, 0, "drive_cmd");
    go(fbsc_pkg::ST_INIT, 1'h0, fbsc_pkg::ST_INIT);
    fbsc_master_model_inst.rx(d);
    chk("drive_cmd.valid", 0, drive_cmd.valid);
    results;
  end
endmodule : tb_fbsc_comm_ctrl
`default_nettype wire
